// >>> src/cmp1_regs.vh
// Purpose: Constants for the first comparator control register
// Assumes: Eight-bit register port, byte-wide data
// Notes: Included by bare name
`ifndef CMP1_REGS_VH
`define CMP1_REGS_VH
`define CMP1_CTRL_ADDR 8'h00
`define CMP1_CTRL_RESET 8'h00
`define CMP1_CTRL_WMASK 8'hb7
`define CMP1_BIT_ENABLE 7
`define CMP1_BIT_RESULT 6
`define CMP1_BIT_PIN_OE 5
`define CMP1_BIT_INVERT 4
`define CMP1_BIT_UNUSED 3
`define CMP1_BIT_NONINV_SEL 2
`define CMP1_CH_MSB 1
`define CMP1_CH_LSB 0
`define CMP1_CH_IN0 2'h0
`define CMP1_CH_IN1 2'h1
`define CMP1_CH_IN2 2'h2
`define CMP1_CH_IN3 2'h3
`endif

// >>> src/cmp1_sync.v
// Purpose: Three-stage synchroniser with agreement filter
// Assumes: Asynchronous level input
// Notes: Output follows once stages two and three agree
`timescale 1ns/1ns
`default_nettype none
module cmp1_sync (
  input wire mclk,
  input wire rst,
  input wire async_in,
  output wire sync_out
);
  reg s1_ff;
  reg s2_ff;
  reg s3_ff;
  reg stable_ff;
  wire nxt_stable;

  assign nxt_stable = (s2_ff == s3_ff) ? s3_ff : stable_ff;

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
      s3_ff <= 1'b0;
      stable_ff <= 1'b0;
    end else begin
      s1_ff <= async_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      stable_ff <= nxt_stable;
    end
  end

  assign sync_out = stable_ff;
endmodule
`default_nettype wire

// >>> src/cmp1_ctrl.v
// Purpose: Control and status register of the first comparator
// Assumes: Raw comparator decision arrives asynchronously
// Notes: One register at one address, read data one cycle later
//
// Summary of operation
// (R01) Bit seven enables the comparator; one on, zero off.
// (R02) Bit five routes the result to the output pin.
// (R03) Bits one and zero pick one of four inverting inputs.
// (R04) Code zero-zero selects analog input zero.
// (R05) Code zero-one selects analog input one.
// (R06) Result bit six is read-only; bit three reads zero.
// (R07) Polarity bit one inverts the result, zero passes it.
// (R08) Pin driven only with pin enable, comparator enable and output direction.
// (R09) Each access captures the result into the change-detect latch; here only accesses at address 8'h00 capture it.
// (R10) Reset clears the register, turning the comparator off.
//
// Chosen here: the address map and the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
`include "cmp1_regs.vh"
module cmp1_ctrl (
  input wire mclk,
  input wire rst,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output wire [7:0] reg_rdata,
  input wire comp_raw,
  input wire pin_direction_bit,
  output wire comp_enable_bit,
  output wire noninverting_source_select,
  output wire [1:0] inverting_channel_select,
  output wire [3:0] inverting_input_sel,
  output wire comp_result_bit,
  output wire comp_pin_out,
  output wire comp_pin_oe_n,
  output wire change_mismatch
);
  localparam integer CH_N = 4;
  localparam [3:0] INSEL_RESET = 4'h1;

  reg [7:0] ctrl_ff;
  reg [7:0] nxt_ctrl;
  reg result_ff;
  reg nxt_result;
  reg snap_ff;
  reg nxt_snap;
  reg [7:0] rdata_ff;
  reg [7:0] nxt_rdata;
  reg oe_n_ff;
  reg nxt_oe_n;
  wire raw_sync;
  wire wr_hit;
  wire rd_hit;
  wire fld_enable;
  wire fld_pin_oe;
  wire fld_invert;
  wire fld_noninv;
  wire [1:0] fld_channel;
  wire [3:0] dec_sel;
  wire [3:0] insel_vec;
  wire drive_ok;
  wire [7:0] read_view;

  // Register address match
  function addr_hit;
    input [7:0] addr;
    begin
      addr_hit = (addr == `CMP1_CTRL_ADDR);
    end
  endfunction

  // One-hot analog mux for the inverting input
  function [3:0] ch_decode;
    input [1:0] ch;
    begin
      case (ch)
        `CMP1_CH_IN0: ch_decode = 4'h1;
        `CMP1_CH_IN1: ch_decode = 4'h2;
        `CMP1_CH_IN2: ch_decode = 4'h4;
        `CMP1_CH_IN3: ch_decode = 4'h8;
        default: ch_decode = 4'h1;
      endcase
    end
  endfunction

  cmp1_sync u_sync (
    .mclk(mclk),
    .rst(rst),
    .async_in(comp_raw),
    .sync_out(raw_sync)
  );

  assign wr_hit = reg_wr & addr_hit(reg_addr);
  assign rd_hit = reg_rd & addr_hit(reg_addr);

  // Field taps
  assign fld_enable = ctrl_ff[`CMP1_BIT_ENABLE];
  assign fld_pin_oe = ctrl_ff[`CMP1_BIT_PIN_OE];
  assign fld_invert = ctrl_ff[`CMP1_BIT_INVERT];
  assign fld_noninv = ctrl_ff[`CMP1_BIT_NONINV_SEL];
  assign fld_channel = ctrl_ff[`CMP1_CH_MSB:`CMP1_CH_LSB];

  // (R06) Read-only and zero bits
  assign read_view = {fld_enable, result_ff, fld_pin_oe, fld_invert, 1'b0, fld_noninv, fld_channel};

  // (R06) Writable bits only
  always @* begin
    nxt_ctrl = ctrl_ff;
    if (wr_hit) begin
      nxt_ctrl = (reg_wdata & `CMP1_CTRL_WMASK) | (ctrl_ff & ~`CMP1_CTRL_WMASK);
    end
  end

  // (R07) Polarity applied
  always @* begin
    nxt_result = 1'b0;
    if (fld_enable) begin
      nxt_result = raw_sync ^ fld_invert;
    end
  end

  // (R09) Capture on access
  always @* begin
    nxt_snap = snap_ff;
    if (wr_hit || rd_hit) begin
      nxt_snap = result_ff;
    end
  end

  // (R08) Pin drive condition
  assign drive_ok = fld_pin_oe & fld_enable & ~pin_direction_bit;

  always @* begin
    nxt_oe_n = 1'b1;
    if (drive_ok) begin
      nxt_oe_n = 1'b0;
    end
  end

  // Read data for one cycle
  always @* begin
    nxt_rdata = 8'h00;
    if (rd_hit) begin
      nxt_rdata = read_view;
    end
  end

  // (R10) Reset to zeros
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      ctrl_ff <= `CMP1_CTRL_RESET;
    end else begin
      ctrl_ff <= nxt_ctrl;
    end
  end

  // (R10) Result off in reset
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      result_ff <= 1'b0;
    end else begin
      result_ff <= nxt_result;
    end
  end

  // (R09) Change-detect latch
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      snap_ff <= 1'b0;
    end else begin
      snap_ff <= nxt_snap;
    end
  end

  // Read data register
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      rdata_ff <= 8'h00;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  // (R08) Pin drive register
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      oe_n_ff <= 1'b1;
    end else begin
      oe_n_ff <= nxt_oe_n;
    end
  end

  // (R04) (R05) Code to one-hot
  assign dec_sel = ch_decode(fld_channel);

  // (R03) One select flop per input
  genvar gi;
  generate
    for (gi = 0; gi < CH_N; gi = gi + 1) begin : g_insel
      reg sel_ff;
      wire nxt_sel;
      assign nxt_sel = dec_sel[gi];
      always @(posedge mclk or posedge rst) begin
        if (rst) begin
          sel_ff <= INSEL_RESET[gi];
        end else begin
          sel_ff <= nxt_sel;
        end
      end
      assign insel_vec[gi] = sel_ff;
    end
  endgenerate

  // (R01) Enable to analog core
  assign comp_enable_bit = fld_enable;
  assign noninverting_source_select = fld_noninv;
  assign inverting_channel_select = fld_channel;
  // (R04) (R05) Registered one-hot selects for inputs zero to three
  assign inverting_input_sel = insel_vec;
  assign comp_result_bit = result_ff;
  // (R02) Result to pin
  assign comp_pin_out = result_ff;
  assign comp_pin_oe_n = oe_n_ff;
  // (R09) Captured versus current
  assign change_mismatch = snap_ff ^ result_ff;
  assign reg_rdata = rdata_ff;
endmodule
`default_nettype wire

// >>> testbench/cmp1_ctrl_asserts.sv
// Purpose: Port checks
// Assumes: One clock
// Notes: Bound below
`timescale 1ns/1ns
`default_nettype none
module cmp1_ctrl_asserts (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic pin_direction_bit,
  input wire logic comp_enable_bit,
  input wire logic [1:0] inverting_channel_select,
  input wire logic [3:0] inverting_input_sel,
  input wire logic comp_result_bit,
  input wire logic comp_pin_out,
  input wire logic comp_pin_oe_n,
  input wire logic change_mismatch
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  logic oe_shadow_ff;
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      oe_shadow_ff <= 1'b0;
    end else if (reg_wr && reg_addr == 8'h00) begin
      oe_shadow_ff <= reg_wdata[5];
    end
  end
  sequence s_rd; reg_rd && reg_addr == 8'h00; endsequence
  sequence s_wr; reg_wr && reg_addr == 8'h00; endsequence
  a_rd_fields: assert property (s_rd |=> reg_rdata[7:6] == {$past(comp_enable_bit), $past(comp_result_bit)} && !reg_rdata[3])
    else $error("read fields");
  a_wr_enable: assert property (s_wr |=> comp_enable_bit == $past(reg_wdata[7]))
    else $error("enable bit");
  a_wr_channel: assert property (s_wr |=> inverting_channel_select == $past(reg_wdata[1:0]))
    else $error("channel field");
  a_sel_zero: assert property (inverting_channel_select == 2'h0 |=> inverting_input_sel == 4'h1)
    else $error("input zero");
  a_sel_one: assert property (inverting_channel_select == 2'h1 |=> inverting_input_sel == 4'h2)
    else $error("input one");
  a_oe_gate: assert property (!comp_enable_bit || pin_direction_bit |=> comp_pin_oe_n)
    else $error("pin drive");
  a_off_zero: assert property (!comp_enable_bit |=> !comp_result_bit)
    else $error("result while off");
  a_read_capture: assert property (s_rd ##1 $stable(comp_result_bit) |-> !change_mismatch)
    else $error("capture");
  a_pin_mirror: assert property (comp_pin_out == comp_result_bit)
    else $error("pin value");
  a_pin_drive: assert property (oe_shadow_ff && comp_enable_bit && !pin_direction_bit |=> !comp_pin_oe_n)
    else $error("pin not driven");
endmodule
bind cmp1_ctrl cmp1_ctrl_asserts cmp1_ctrl_asserts_inst (.*);
`default_nettype wire

// >>> testbench/cmp1_src.sv
// Purpose: Analog side model
// Assumes: Level decision
// Notes: Skewed from clock
`timescale 1ns/1ns
`default_nettype none
module cmp1_src (
  input wire logic level,
  output wire logic comp_raw
);
  assign #7 comp_raw = level;
endmodule
`default_nettype wire

// >>> testbench/cmp1_ctrl_tb_top.sv
// Purpose: Bench for cmp1_ctrl
// Assumes: Register port
// Notes: Row table then edge cases
`timescale 1ns/1ns
`default_nettype none
module cmp1_ctrl_tb_top;
  logic mclk, rst, reg_wr, reg_rd, level, pdir, res, oe_n, mm, nsel;
  logic [7:0] reg_addr, reg_wdata, rdata, q;
  logic [3:0] sel;
  wire logic raw;
  int num_errors, checks, cyc;
  logic [15:0] rows [5] = '{16'hfff7, 16'h4800, 16'h8181, 16'h92d2, 16'h3434};
  cmp1_src cmp1_src_inst (.level(level), .comp_raw(raw));
  cmp1_ctrl cmp1_ctrl_inst (.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(rdata), .comp_raw(raw), .pin_direction_bit(pdir), .comp_enable_bit(),
    .noninverting_source_select(nsel), .inverting_channel_select(), .inverting_input_sel(sel),
    .comp_result_bit(res), .comp_pin_out(), .comp_pin_oe_n(oe_n), .change_mismatch(mm));
  always #25 mclk = ~mclk;
  task chk(input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge mclk) reg_wr <= 1'b0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge mclk) {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge mclk) reg_rd <= 1'b0;
    @(posedge mclk) q = rdata;
  endtask
  task tally_and_finish;
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  always @(posedge mclk) if (++cyc == 1000) begin
    num_errors++;
    tally_and_finish;
  end
  initial begin
    {mclk, rst, reg_wr, reg_rd, level, pdir, reg_addr, reg_wdata} = {5'h08, 1'b1, 16'h0000};
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    foreach (rows[i]) begin
      wr(8'h00, rows[i][15:8]);
      repeat (3) @(posedge mclk);
      rd(8'h00);
      chk(rows[i][7:0], q);
      chk(8'h01 << rows[i][9:8], {4'h0, sel});
      chk({7'h0, rows[i][10]}, {7'h0, nsel});
      $display("row %0d done", i);
    end
    pdir <= 1'b0;
    wr(8'h00, 8'ha0);
    level <= 1'b1;
    repeat (8) @(posedge mclk);
    #1 chk(8'h05, {5'h0, res, oe_n, mm});
    rd(8'h05);
    chk(8'h00, q);
    chk(8'h01, {7'h0, mm});
    rd(8'h00);
    chk(8'he0, q);
    chk(8'h00, {7'h0, mm});
    $display("drive test done");
    @(posedge mclk) rst <= 1'b1;
    @(posedge mclk) rst <= 1'b0;
    rd(8'h00);
    chk(8'h01, {q[7:1], oe_n});
    chk(8'h01, {4'h0, sel});
    $display("reset test done");
    tally_and_finish;
  end
endmodule
`default_nettype wire
